// [src/tws_pkg.sv]
// Purpose: shared constants and types for the two-wire memory slave front end
// Assumes: system clock of 25 MHz
// Notes: size codes select the memory variant
package tws_pkg;
    // clock and programming time
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned PROG_TIME_MS = 5;
    localparam int unsigned PROG_CYC = (PROG_TIME_MS * CLK_HZ) / 1000;
    localparam int PROG_W = 17;
    ////////////////////////////////////////////////////////////////////////////
    // device select and variants
    localparam logic [3:0] DEVSEL_PATTERN = 4'ha;
    localparam logic [1:0] SZ_128 = 2'h0;
    localparam logic [1:0] SZ_256 = 2'h1;
    localparam logic [1:0] SZ_512 = 2'h2;
    localparam logic [1:0] SZ_1024 = 2'h3;
    localparam logic [9:0] MASK_128 = 10'h07f;
    localparam logic [9:0] MASK_256 = 10'h0ff;
    localparam logic [9:0] MASK_512 = 10'h1ff;
    localparam logic [9:0] MASK_1024 = 10'h3ff;
    localparam logic [9:0] PAGE_MASK_SMALL = 10'h007;
    localparam logic [9:0] PAGE_MASK_LARGE = 10'h00f;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    ////////////////////////////////////////////////////////////////////////////
    // reset values and buffer shape
    localparam logic [7:0] PIN_RESET = 8'hc0;
    localparam logic [9:0] ADDR_RESET = 10'h000;
    localparam int FIFO_WIDTH = 18;
    localparam int FIFO_DEPTH = 32;
    ////////////////////////////////////////////////////////////////////////////
    // state machine
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_RX = 3'h1,
        ST_ACKSET = 3'h2,
        ST_ACK = 3'h3,
        ST_TX = 3'h4,
        ST_MACK = 3'h5,
        ST_MLOAD = 3'h6
    } tws_state_type;
    typedef enum logic [1:0] {
        KD_DEV = 2'h0,
        KD_ADDR = 2'h1,
        KD_DATA = 2'h2
    } tws_kind_type;
endpackage

// [src/tws_fifo.sv]
// Purpose: write byte buffer with registered read side
// Assumes: single clock, flush empties everything
// Notes: holds DEPTH words plus one in the output register
`timescale 1ns/100ps
module tws_fifo
#(
    parameter int WIDTH = tws_pkg::FIFO_WIDTH,
    parameter int DEPTH = tws_pkg::FIFO_DEPTH
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic flush,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic empty
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] count_ff;
    logic ovalid_ff;
    logic [WIDTH-1:0] odata_ff;
    logic push;
    logic load;
    logic [AW:0] nxt_count;
    ////////////////////////////////////////////////////////////////////////////
    // control decode
    assign in_ready = count_ff != (AW + 1)'(DEPTH);
    assign push = in_valid & in_ready & ~flush;
    assign load = (count_ff != '0) & (~ovalid_ff | out_ready) & ~flush;
    assign nxt_count = count_ff + (AW + 1)'(push) - (AW + 1)'(load);
    assign out_valid = ovalid_ff;
    assign out_data = odata_ff;
    assign empty = (count_ff == '0) & ~ovalid_ff;
    ////////////////////////////////////////////////////////////////////////////
    // storage
    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_ptr_ff] <= in_data;
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
            ovalid_ff <= 1'h0;
            odata_ff <= '0;
        end
        else if (flush)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
            ovalid_ff <= 1'h0;
        end
        else
        begin
            if (push)
                wr_ptr_ff <= wr_ptr_ff + AW'(1);
            if (load)
            begin
                rd_ptr_ff <= rd_ptr_ff + AW'(1);
                odata_ff <= mem[rd_ptr_ff];
            end
            count_ff <= nxt_count;
            ovalid_ff <= load | (ovalid_ff & ~out_ready);
        end
    end
endmodule

// [src/tws_front.sv]
// Purpose: two-wire serial slave front end of a byte wide nonvolatile memory
// Assumes: SCL and SDA sampled by CLK_SYS; memory array sits outside this block
// Notes: received bytes wait in a buffer and are written out during programming
`timescale 1ns/100ps
module tws_front
#(
    parameter int unsigned PROG_CYCLES = tws_pkg::PROG_CYC
)
(
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RESETN,
    // serial bus
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    // straps
    input wire logic CHIP_SELECT_PIN_HIGH,
    input wire logic CHIP_SELECT_PIN_MID,
    input wire logic CHIP_SELECT_PIN_LOW,
    input wire logic WRITE_PROTECT,
    input wire logic [1:0] SIZE_SEL,
    // memory read port
    output logic [9:0] MEM_RD_ADDR,
    input wire logic [7:0] MEM_RD_DATA,
    // memory write port
    output logic MEM_WR_STROBE,
    output logic [9:0] MEM_WR_ADDR,
    output logic [7:0] MEM_WR_DATA,
    input wire logic MEM_WR_READY,
    // status
    output logic STANDBY,
    output logic BUSY
);
    ////////////////////////////////////////////////////////////////////////////
    // decode functions
    function automatic logic [9:0] size_mask(input logic [1:0] sz);
        case (sz)
            tws_pkg::SZ_128: size_mask = tws_pkg::MASK_128;
            tws_pkg::SZ_256: size_mask = tws_pkg::MASK_256;
            tws_pkg::SZ_512: size_mask = tws_pkg::MASK_512;
            default: size_mask = tws_pkg::MASK_1024;
        endcase
    endfunction

    function automatic logic dev_match(input logic [7:0] b, input logic [1:0] sz, input logic [2:0] cs);
        logic sel_ok;
        sel_ok = 1'h0;
        case (sz)
            tws_pkg::SZ_512: sel_ok = b[3:2] == cs[2:1];
            tws_pkg::SZ_1024: sel_ok = b[3] == cs[2];
            default: sel_ok = b[3:1] == cs;
        endcase
        dev_match = (b[7:4] == tws_pkg::DEVSEL_PATTERN) & sel_ok;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // reset release and pin synchronisers
    logic [1:0] rst_sync_ff;
    logic rst_n;
    logic [7:0] pins_raw;
    logic [7:0] meta_ff;
    logic [7:0] sync_ff;
    logic scl_d_ff;
    logic sda_d_ff;

    always_ff @(posedge CLK_SYS or negedge RESETN)
    begin
        if (!RESETN)
            rst_sync_ff <= 2'h0;
        else
            rst_sync_ff <= {rst_sync_ff[0], 1'h1};
    end
    assign rst_n = rst_sync_ff[1];

    assign pins_raw = {SCL_IN, SDA_IN, CHIP_SELECT_PIN_HIGH, CHIP_SELECT_PIN_MID,
                       CHIP_SELECT_PIN_LOW, WRITE_PROTECT, SIZE_SEL};

    always_ff @(posedge CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_ff <= tws_pkg::PIN_RESET;
            sync_ff <= tws_pkg::PIN_RESET;
            scl_d_ff <= 1'h1;
            sda_d_ff <= 1'h1;
        end
        else
        begin
            meta_ff <= pins_raw;
            sync_ff <= meta_ff;
            scl_d_ff <= sync_ff[7];
            sda_d_ff <= sync_ff[6];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus events and variant decode
    logic scl_s;
    logic sda_s;
    logic [2:0] cs_s;
    logic wp_s;
    logic [1:0] size_s;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic [9:0] smask;
    logic [9:0] pmask;

    assign scl_s = sync_ff[7];
    assign sda_s = sync_ff[6];
    assign cs_s = sync_ff[5:3];
    assign wp_s = sync_ff[2];
    assign size_s = sync_ff[1:0];
    assign scl_rise = scl_s & ~scl_d_ff;
    assign scl_fall = ~scl_s & scl_d_ff;
    assign start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    assign stop_det = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
    assign smask = size_mask(size_s);
    assign pmask = size_s[1] ? tws_pkg::PAGE_MASK_LARGE : tws_pkg::PAGE_MASK_SMALL;

    ////////////////////////////////////////////////////////////////////////////
    // state registers
    tws_pkg::tws_state_type state_ff, nxt_state;
    tws_pkg::tws_kind_type kind_ff, nxt_kind;
    logic [3:0] cnt_ff, nxt_cnt;
    logic [7:0] shift_ff, nxt_shift;
    logic [7:0] tx_ff, nxt_tx;
    logic ack_ff, nxt_ack;
    logic rw_ff, nxt_rw;
    logic [1:0] page_sel_ff, nxt_page_sel;
    logic [9:0] addr_ff, nxt_addr;
    logic sda_oe_ff, nxt_sda_oe;
    logic wr_pend_ff, nxt_wr_pend;
    logic busy_ff, nxt_busy;
    logic [tws_pkg::PROG_W-1:0] prog_cnt_ff, nxt_prog_cnt;
    logic standby_ff;
    logic [9:0] rd_addr_ff;
    logic wr_strobe_ff;
    logic [9:0] wr_addr_ff;
    logic [7:0] wr_data_ff;
    logic sda_out_ff;

    ////////////////////////////////////////////////////////////////////////////
    // datapath decode
    logic [7:0] byte_in;
    logic page_select_bit_low;
    logic page_select_bit_high;
    logic dev_ok;
    logic data_ok;
    logic rx_ack;
    logic [9:0] addr_page_inc;
    logic [9:0] addr_lin_inc;
    logic [9:0] addr_hi;
    logic fifo_push;
    logic fifo_flush;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [17:0] fifo_out_data;
    logic fifo_empty;
    logic fifo_pop;
    logic prog_start;
    logic prog_done;

    assign byte_in = {shift_ff[6:0], sda_s};
    assign page_select_bit_low = byte_in[1];
    assign page_select_bit_high = byte_in[2];
    assign dev_ok = dev_match(byte_in, size_s, cs_s) & ~busy_ff;
    assign data_ok = fifo_in_ready | wp_s;
    assign rx_ack = (kind_ff == tws_pkg::KD_DEV) ? dev_ok : ((kind_ff == tws_pkg::KD_DATA) ? data_ok : 1'h1);
    assign addr_page_inc = (addr_ff & ~pmask) | ((addr_ff + 10'h001) & pmask);
    assign addr_lin_inc = (addr_ff + 10'h001) & smask;
    assign addr_hi = addr_ff & ~pmask;
    assign prog_start = stop_det & wr_pend_ff & ~busy_ff;
    assign prog_done = busy_ff & (prog_cnt_ff == '0) & fifo_empty;
    assign nxt_busy = prog_start | (busy_ff & ~prog_done);
    assign nxt_prog_cnt = prog_start ? tws_pkg::PROG_W'(PROG_CYCLES - 1) :
                          ((prog_cnt_ff != '0) ? prog_cnt_ff - tws_pkg::PROG_W'(1) : prog_cnt_ff);
    assign fifo_out_ready = busy_ff & MEM_WR_READY;
    assign fifo_pop = fifo_out_valid & fifo_out_ready;

    ////////////////////////////////////////////////////////////////////////////
    // protocol state machine
    always_comb
    begin
        nxt_state = state_ff;
        nxt_kind = kind_ff;
        nxt_cnt = cnt_ff;
        nxt_shift = shift_ff;
        nxt_tx = tx_ff;
        nxt_ack = ack_ff;
        nxt_rw = rw_ff;
        nxt_page_sel = page_sel_ff;
        nxt_addr = addr_ff;
        nxt_sda_oe = sda_oe_ff;
        nxt_wr_pend = wr_pend_ff;
        fifo_push = 1'h0;
        fifo_flush = 1'h0;
        if (start_det)
        begin
            nxt_state = tws_pkg::ST_RX;
            nxt_kind = tws_pkg::KD_DEV;
            nxt_cnt = 4'h0;
            nxt_sda_oe = 1'h0;
            fifo_flush = wr_pend_ff;
            nxt_wr_pend = 1'h0;
        end
        else if (stop_det)
        begin
            nxt_state = tws_pkg::ST_IDLE;
            nxt_sda_oe = 1'h0;
            nxt_wr_pend = 1'h0;
        end
        else
        begin
            case (state_ff)
                tws_pkg::ST_RX:
                begin
                    if (scl_rise)
                    begin
                        nxt_shift = byte_in;
                        nxt_cnt = cnt_ff + 4'h1;
                        if (cnt_ff == tws_pkg::LAST_BIT)
                        begin
                            nxt_state = tws_pkg::ST_ACKSET;
                            nxt_ack = rx_ack;
                            if (kind_ff == tws_pkg::KD_DEV)
                            begin
                                nxt_rw = byte_in[0];
                                nxt_page_sel = {page_select_bit_high, page_select_bit_low};
                            end
                            else if (kind_ff == tws_pkg::KD_ADDR)
                                nxt_addr = {page_sel_ff, byte_in} & smask;
                            else if (data_ok)
                            begin
                                fifo_push = ~wp_s;
                                nxt_wr_pend = wr_pend_ff | ~wp_s;
                                nxt_addr = addr_page_inc;
                            end
                        end
                    end
                end
                tws_pkg::ST_ACKSET:
                begin
                    if (scl_fall)
                    begin
                        nxt_sda_oe = ack_ff;
                        nxt_state = ack_ff ? tws_pkg::ST_ACK : tws_pkg::ST_IDLE;
                    end
                end
                tws_pkg::ST_ACK:
                begin
                    if (scl_fall)
                    begin
                        nxt_cnt = 4'h0;
                        nxt_sda_oe = 1'h0;
                        if (kind_ff == tws_pkg::KD_DEV && rw_ff)
                        begin
                            nxt_state = tws_pkg::ST_TX;
                            nxt_tx = {MEM_RD_DATA[6:0], 1'h0};
                            nxt_sda_oe = ~MEM_RD_DATA[7];
                        end
                        else
                        begin
                            nxt_state = tws_pkg::ST_RX;
                            nxt_kind = (kind_ff == tws_pkg::KD_DEV) ? tws_pkg::KD_ADDR : tws_pkg::KD_DATA;
                        end
                    end
                end
                tws_pkg::ST_TX:
                begin
                    if (scl_rise)
                    begin
                        nxt_cnt = cnt_ff + 4'h1;
                        if (cnt_ff == tws_pkg::LAST_BIT)
                            nxt_addr = addr_lin_inc;
                    end
                    else if (scl_fall)
                    begin
                        if (cnt_ff == tws_pkg::ACK_SLOT)
                        begin
                            nxt_sda_oe = 1'h0;
                            nxt_state = tws_pkg::ST_MACK;
                        end
                        else
                        begin
                            nxt_sda_oe = ~tx_ff[7];
                            nxt_tx = {tx_ff[6:0], 1'h0};
                        end
                    end
                end
                tws_pkg::ST_MACK:
                begin
                    if (scl_rise)
                        nxt_state = sda_s ? tws_pkg::ST_IDLE : tws_pkg::ST_MLOAD;
                end
                tws_pkg::ST_MLOAD:
                begin
                    if (scl_fall)
                    begin
                        nxt_state = tws_pkg::ST_TX;
                        nxt_cnt = 4'h0;
                        nxt_tx = {MEM_RD_DATA[6:0], 1'h0};
                        nxt_sda_oe = ~MEM_RD_DATA[7];
                    end
                end
                default:
                begin
                    nxt_state = tws_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff <= tws_pkg::ST_IDLE;
            kind_ff <= tws_pkg::KD_DEV;
            cnt_ff <= 4'h0;
            shift_ff <= 8'h00;
            tx_ff <= 8'h00;
            ack_ff <= 1'h0;
            rw_ff <= 1'h0;
            page_sel_ff <= 2'h0;
            addr_ff <= tws_pkg::ADDR_RESET;
            sda_oe_ff <= 1'h0;
            wr_pend_ff <= 1'h0;
            busy_ff <= 1'h0;
            prog_cnt_ff <= '0;
            standby_ff <= 1'h1;
            rd_addr_ff <= tws_pkg::ADDR_RESET;
            wr_strobe_ff <= 1'h0;
            wr_addr_ff <= tws_pkg::ADDR_RESET;
            wr_data_ff <= 8'h00;
            sda_out_ff <= 1'h0;
        end
        else
        begin
            state_ff <= nxt_state;
            kind_ff <= nxt_kind;
            cnt_ff <= nxt_cnt;
            shift_ff <= nxt_shift;
            tx_ff <= nxt_tx;
            ack_ff <= nxt_ack;
            rw_ff <= nxt_rw;
            page_sel_ff <= nxt_page_sel;
            addr_ff <= nxt_addr;
            sda_oe_ff <= nxt_sda_oe;
            wr_pend_ff <= nxt_wr_pend;
            busy_ff <= nxt_busy;
            prog_cnt_ff <= nxt_prog_cnt;
            standby_ff <= (nxt_state == tws_pkg::ST_IDLE) & ~nxt_busy;
            rd_addr_ff <= nxt_addr;
            sda_out_ff <= 1'h0;
            wr_strobe_ff <= fifo_pop;
            if (fifo_pop)
            begin
                wr_addr_ff <= fifo_out_data[17:8];
                wr_data_ff <= fifo_out_data[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // write byte buffer
    tws_fifo #(
        .WIDTH(tws_pkg::FIFO_WIDTH),
        .DEPTH(tws_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(CLK_SYS),
        .rst_n(rst_n),
        .flush(fifo_flush),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .in_data({addr_ff, byte_in}),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data),
        .empty(fifo_empty)
    );

    assign SDA_OUT = sda_out_ff;
    assign SDA_OE = sda_oe_ff;
    assign MEM_RD_ADDR = rd_addr_ff;
    assign MEM_WR_STROBE = wr_strobe_ff;
    assign MEM_WR_ADDR = wr_addr_ff;
    assign MEM_WR_DATA = wr_data_ff;
    assign STANDBY = standby_ff;
    assign BUSY = busy_ff;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!rst_n);

    sequence s_ack_begin;
        state_ff == tws_pkg::ST_ACKSET && ack_ff && scl_fall;
    endsequence
    sequence s_ack_drive;
        sda_oe_ff && state_ff == tws_pkg::ST_ACK;
    endsequence

    a_ack_ninth_clock: assert property (s_ack_begin |=> s_ack_drive)
        else $error("acknowledge not driven in ninth clock");
    a_sda_open_drain: assert property (SDA_OUT == 1'h0 && (!sda_oe_ff || state_ff == tws_pkg::ST_ACK
        || state_ff == tws_pkg::ST_TX))
        else $error("sda driven high or pulled low outside an ack or data slot");
    a_start_restarts_rx: assert property (start_det |=> state_ff == tws_pkg::ST_RX && cnt_ff == 4'h0
        && kind_ff == tws_pkg::KD_DEV && !sda_oe_ff)
        else $error("start did not restart receive");
    a_stop_goes_idle: assert property (stop_det |=> state_ff == tws_pkg::ST_IDLE && !sda_oe_ff)
        else $error("stop did not return to idle");
    a_read_stop_standby: assert property (stop_det && !wr_pend_ff && !busy_ff |=> STANDBY)
        else $error("no standby after stop");
    a_busy_select_nack: assert property (state_ff == tws_pkg::ST_RX && kind_ff == tws_pkg::KD_DEV && busy_ff
        && scl_rise && cnt_ff == tws_pkg::LAST_BIT |=> !ack_ff)
        else $error("select acknowledged while programming");
    a_protect_no_push: assert property (fifo_push |-> !wp_s)
        else $error("write accepted while protected");
    a_page_wrap_upper: assert property (fifo_push |=> addr_hi == $past(addr_hi) && $changed(addr_ff))
        else $error("page write moved upper address bits");
    a_rx_on_rise: assert property (state_ff == tws_pkg::ST_RX && !scl_rise |=> $stable(shift_ff))
        else $error("receive shift without rising clock");
    a_tx_on_fall: assert property (state_ff == tws_pkg::ST_TX && !scl_fall && !start_det && !stop_det
        |=> $stable(sda_oe_ff))
        else $error("sda changed without falling clock");
    a_prog_load: assert property ($rose(busy_ff) |-> prog_cnt_ff == tws_pkg::PROG_W'(PROG_CYCLES - 1))
        else $error("programming time not loaded");
endmodule

// [sim/tws_mst.sv]
// Purpose: two-wire bus master model driving SCL and SDA
// Assumes: SDA pulled up, each clock phase 10 system clocks
// Notes: tasks are called by the bench
`timescale 1ns/100ps
module tws_mst
(
    input wire logic clk,
    input wire logic sda_oe,
    output logic scl,
    output logic sda
);
    logic m_sda = 1'b1;
    initial scl = 1'b1;
    // wired-and of master and slave, pulled up when released
    assign sda = m_sda & ~sda_oe;
    task w(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task bt(input logic b, output logic r);
        m_sda = b;
        w(5);
        scl = 1'b1;
        w(5);
        r = sda;
        w(5);
        scl = 1'b0;
        w(5);
    endtask
    task start;
        m_sda = 1'b1;
        w(5);
        scl = 1'b1;
        w(5);
        m_sda = 1'b0;
        w(5);
        scl = 1'b0;
        w(5);
    endtask
    task stop;
        m_sda = 1'b0;
        w(5);
        scl = 1'b1;
        w(5);
        m_sda = 1'b1;
        w(10);
    endtask
    task xb(input logic [7:0] d, input logic mk, output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--) bt(d[i], q[i]);
        bt(mk, a);
        a = ~a;
    endtask
endmodule

// [sim/test_tws_front.sv]
// Purpose: self-checking bench for the two-wire slave front end
// Assumes: array modelled here, combinational read
// Notes: select rows first, then write, read, protect and recovery
`timescale 1ns/100ps
module test_tws_front;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr_rdy = 1'b1;
    logic wp = 1'b0;
    logic scl, sda, oe, ws, stb, busy, a, so;
    logic [1:0] sz = tws_pkg::SZ_128;
    logic [9:0] rd_adr, wr_adr;
    logic [7:0] wr_dat, q;
    logic [7:0] mem [1024];
    logic [10:0] rows [9] = '{{2'h0, 8'haa, 1'h1}, {2'h0, 8'ha8, 1'h0}, {2'h0, 8'hba, 1'h0},
        {2'h2, 8'ha8, 1'h1}, {2'h2, 8'haa, 1'h1}, {2'h2, 8'hac, 1'h0},
        {2'h3, 8'ha8, 1'h1}, {2'h3, 8'hae, 1'h1}, {2'h3, 8'ha0, 1'h0}};
    logic [7:0] rx [3] = '{8'h11, 8'h22, 8'h00};
    int n_mismatch = 0;
    int total_checks = 0;
    always #20 clk = ~clk;
    always @(posedge clk) wr_rdy <= #1 ~wr_rdy;
    always @(posedge clk) if (ws) mem[wr_adr] <= wr_dat;
    tws_mst u_tws_mst (.clk(clk), .sda_oe(oe), .scl(scl), .sda(sda));
    tws_front #(.PROG_CYCLES(400)) u_tws_front (.CLK_SYS(clk), .RESETN(rst_n), .SCL_IN(scl), .SDA_IN(sda),
        .SDA_OUT(so), .SDA_OE(oe), .CHIP_SELECT_PIN_HIGH(1'b1), .CHIP_SELECT_PIN_MID(1'b0),
        .CHIP_SELECT_PIN_LOW(1'b1), .WRITE_PROTECT(wp), .SIZE_SEL(sz), .MEM_RD_ADDR(rd_adr),
        .MEM_RD_DATA(mem[rd_adr]), .MEM_WR_STROBE(ws), .MEM_WR_ADDR(wr_adr), .MEM_WR_DATA(wr_dat),
        .MEM_WR_READY(wr_rdy), .STANDBY(stb), .BUSY(busy));
    ////////////////////////////////////////////////////////////////////////////
    task chk(input string n, input logic [9:0] s, input logic [9:0] e);
        total_checks++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task tx(input logic [7:0] d, input logic e);
        u_tws_mst.xb(d, 1'b1, q, a);
        chk("ack", 10'(a), 10'(e));
    endtask
    task end_sim;
        if (n_mismatch == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        #3ms;
        n_mismatch++;
        end_sim;
    end
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        for (int i = 0; i < 1024; i++) mem[i] = i[7:0];
        repeat (5) @(posedge clk);
        chk("standby", 10'(stb), 10'h1);
        chk("busy", 10'(busy), 10'h0);
        #1 rst_n = 1'b1;
        repeat (8) @(posedge clk);
        foreach (rows[i])
        begin
            sz = rows[i][10:9];
            u_tws_mst.start;
            tx(rows[i][8:1], rows[i][0]);
            u_tws_mst.stop;
        end
        sz = tws_pkg::SZ_256;
        u_tws_mst.start;
        tx(8'haa, 1'b1);
        tx(8'hfe, 1'b1);
        tx(8'h11, 1'b1);
        tx(8'h22, 1'b1);
        tx(8'h33, 1'b1);
        u_tws_mst.stop;
        chk("busy", 10'(busy), 10'h1);
        u_tws_mst.start;
        tx(8'haa, 1'b0);
        u_tws_mst.stop;
        repeat (2000) if (busy === 1'b1) @(posedge clk);
        chk("standby", 10'(stb), 10'h1);
        chk("wrap", 10'(mem[10'hfe]), 10'h011);
        chk("wrap", 10'(mem[10'hff]), 10'h022);
        chk("wrap", 10'(mem[10'hf8]), 10'h33);
        u_tws_mst.start;
        tx(8'haa, 1'b1);
        tx(8'hfe, 1'b1);
        u_tws_mst.start;
        tx(8'hab, 1'b1);
        for (int k = 0; k < 3; k++)
        begin
            u_tws_mst.xb(8'hff, k == 2, q, a);
            chk("read", 10'(q), 10'(rx[k]));
        end
        u_tws_mst.stop;
        chk("standby", 10'(stb), 10'h1);
        wp = 1'b1;
        u_tws_mst.start;
        tx(8'haa, 1'b1);
        tx(8'h10, 1'b1);
        tx(8'h5a, 1'b1);
        u_tws_mst.stop;
        chk("protect", {busy, 1'b0, mem[10'h10]}, 10'h010);
        wp = 1'b0;
        sz = tws_pkg::SZ_512;
        u_tws_mst.start;
        tx(8'haa, 1'b1);
        tx(8'hfe, 1'b1);
        tx(8'h44, 1'b1);
        tx(8'h55, 1'b1);
        tx(8'h66, 1'b1);
        u_tws_mst.stop;
        repeat (2000) if (busy === 1'b1) @(posedge clk);
        chk("large page", 10'(mem[10'h1fe]), 10'h044);
        chk("large page", 10'(mem[10'h1f0]), 10'h066);
        chk("sda out", 10'(so), 10'h000);
        u_tws_mst.start;
        repeat (3) u_tws_mst.bt(1'b1, a);
        u_tws_mst.start;
        repeat (9) u_tws_mst.bt(1'b1, a);
        u_tws_mst.start;
        u_tws_mst.stop;
        u_tws_mst.start;
        tx(8'haa, 1'b1);
        u_tws_mst.stop;
        end_sim;
    end
endmodule
